// File: bcc_channel_ctrl.sv
// Control and configuration logic for one low-voltage buck channel.
// Assumes an Avalon-MM master on sys_clk_i; OTP and sequence inputs are
// static pins from outside and are synchronised before use.
//
// Local design decisions: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module bcc_channel_ctrl #(
   parameter int DISCHARGE_CYC = bcc_pkg::DISCHARGE_CYC
) (
   input  wire logic        sys_clk_i,
   input  wire logic        sys_rst_i,
   // Avalon-MM slave
   input  wire logic [2:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   // OTP and system pins
   input  wire logic [4:0]  otp_setpoint_default_i,
   input  wire logic [1:0]  inductor_value_select_i,
   input  wire logic        in_powerup_seq_i,
   input  wire logic        standby_i,
   // Analog-facing controls
   output logic [4:0]       output_setpoint_code_o,
   output logic [1:0]       operating_mode_field_o,
   output logic             regulator_enable_o,
   output logic             discharge_o,
   output logic [1:0]       peak_current_limit_select_o,
   output logic [2:0]       channel_phase_select_o,
   output logic [8:0]       phase_degrees_o,
   output logic [8:0]       setpoint_centivolt_o,
   output logic [1:0]       inductor_value_select_o,
   output logic             inductor_reserved_o,
   output logic             interrupt_request_n_o
);

   // ****************************************************************
   // Input synchronisers
   // ****************************************************************
   logic [8:0] sync1_r;   // First stage, read only by sync2_r
   logic [8:0] sync2_r;   // Second stage, safe for logic
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         sync1_r <= 9'h0;
         sync2_r <= 9'h0;
      end else begin
         sync1_r <= {standby_i, in_powerup_seq_i, inductor_value_select_i,
                     otp_setpoint_default_i};
         sync2_r <= sync1_r;
      end
   end
   logic [4:0] otp_sp;     // Synchronised OTP set-point
   logic [1:0] otp_ind;    // Synchronised inductor select
   logic       pwr_seq;    // Channel is in the power-up sequence
   logic       stby;       // System in standby
   assign otp_sp  = sync2_r[4:0];
   assign otp_ind = sync2_r[6:5];
   assign pwr_seq = sync2_r[7];
   assign stby    = sync2_r[8];

   // ****************************************************************
   // Post-reset load of OTP defaults
   // ****************************************************************
   // Straps pass the synchroniser first, so the load waits two edges
   logic [1:0] boot_cnt_r;  // Counts edges after release
   logic       loaded_r;    // Defaults have been captured
   logic       load_now;    // One-cycle load strobe
   assign load_now = !loaded_r && (boot_cnt_r == 2'h2);
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         boot_cnt_r <= 2'h0;
         loaded_r   <= 1'b0;
      end else if (!loaded_r) begin
         boot_cnt_r <= boot_cnt_r + 2'h1;
         if (load_now) begin
            loaded_r <= 1'b1;
         end
      end
   end

   // ****************************************************************
   // Bus decode
   // ****************************************************************
   logic        ack_r;      // One wait state, then accept
   logic        ack_nxt;    // Next value of ack_r
   logic        wr_acc;     // Write accepted this edge
   logic        rd_acc;     // Read accepted this edge
   assign wr_acc = avs_write && ack_r;
   assign rd_acc = avs_read && ack_r;
   // Hold off until OTP defaults are in, then one wait per access
   assign ack_nxt = loaded_r && (avs_read || avs_write) && !ack_r;
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         ack_r           <= 1'b0;
         avs_waitrequest <= 1'b1;
      end else begin
         ack_r           <= ack_nxt;
         // Own flop, so the pin carries no gate after the register
         avs_waitrequest <= !ack_nxt;
      end
   end

   // ****************************************************************
   // Configuration registers
   // ****************************************************************
   logic [4:0] setpoint_r;   // Programmed set-point
   logic [1:0] run_mode_r;   // Run-state mode
   logic [1:0] stby_mode_r;  // Standby-state mode
   logic [1:0] ilim_r;       // Peak current limit
   logic [2:0] phase_r;      // Phase select
   logic [0:0] mask_r;       // Mode-change mask
   logic       sp_start;     // Differing set-point written

   bcc_seq_if sq ();
   assign sp_start  = load_now ? 1'b0 :
                      wr_acc && (avs_address == bcc_pkg::ADDR_SETPOINT) &&
                      (avs_writedata[4:0] != setpoint_r);
   assign sq.start  = sp_start;
   assign sq.target = avs_writedata[4:0];

   // Set-point: one code for both run and standby
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         setpoint_r <= 5'h0;
      end else if (load_now) begin
         setpoint_r <= otp_sp;
      end else if (sp_start) begin
         setpoint_r <= sq.target;
      end
   end

   // Mode fields; off at reset, value after the OTP load depends on power-up sequencing strap
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         run_mode_r  <= bcc_pkg::MODE_OFF;
         stby_mode_r <= bcc_pkg::MODE_OFF;
      end else if (load_now) begin
         run_mode_r  <= pwr_seq ? bcc_pkg::MODE_AUTOSKIP : bcc_pkg::MODE_OFF;
         stby_mode_r <= pwr_seq ? bcc_pkg::MODE_AUTOSKIP : bcc_pkg::MODE_OFF;
      end else if (wr_acc && avs_address == bcc_pkg::ADDR_MODE) begin
         run_mode_r  <= avs_writedata[bcc_pkg::RUN_MODE_LSB +: 2];
         stby_mode_r <= avs_writedata[bcc_pkg::STBY_MODE_LSB +: 2];
      end
   end

   // Current limit, phase and mask
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         ilim_r  <= bcc_pkg::ILIM_RST;
         phase_r <= bcc_pkg::PHASE_ZERO;
         mask_r  <= bcc_pkg::MASK_RST;
      end else if (wr_acc) begin
         if (avs_address == bcc_pkg::ADDR_LIMIT) begin
            ilim_r <= avs_writedata[1:0];
         end
         if (avs_address == bcc_pkg::ADDR_PHASE) begin
            phase_r <= avs_writedata[2:0];
         end
         if (avs_address == bcc_pkg::ADDR_MASK) begin
            mask_r <= avs_writedata[0:0];
         end
      end
   end

   // ****************************************************************
   // Sequencer
   // ****************************************************************
   bcc_setpoint_seq #(
      .DISCHARGE_CYC (DISCHARGE_CYC)
   ) u_seq (
      .sys_clk_i (sys_clk_i),
      .sys_rst_i (sys_rst_i),
      .sq        (sq.seq)
   );

   // ****************************************************************
   // Applied mode and mode-change event
   // ****************************************************************
   logic [1:0] mode_sel;      // Mode for current system state
   logic [1:0] mode_r;        // Applied mode
   logic       mode_evt;      // Mode changes this edge
   logic       flag_r;        // Sticky mode-change flag
   // Voltage is shared, so a run/standby swap alters the applied mode but never the set-point
   assign mode_sel = stby ? stby_mode_r : run_mode_r;
   assign mode_evt = loaded_r && (mode_sel != mode_r);
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         mode_r <= bcc_pkg::MODE_OFF;
      end else if (loaded_r) begin
         mode_r <= mode_sel;
      end
   end

   // Set wins over the clear-on-read
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         flag_r <= 1'b0;
      end else if (mode_evt) begin
         flag_r <= 1'b1;
      end else if (rd_acc && avs_address == bcc_pkg::ADDR_STATUS) begin
         flag_r <= 1'b0;
      end
   end

   // ****************************************************************
   // Read data
   // ****************************************************************
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         avs_readdata <= 32'h0;
      end else if (avs_read && !ack_r) begin
         // Captured in the wait cycle so data stands at the accept edge
         unique case (avs_address)
            bcc_pkg::ADDR_SETPOINT: avs_readdata <= {27'h0, setpoint_r};
            bcc_pkg::ADDR_MODE:     avs_readdata <= {28'h0, stby_mode_r, run_mode_r};
            bcc_pkg::ADDR_LIMIT:    avs_readdata <= {30'h0, ilim_r};
            bcc_pkg::ADDR_PHASE:    avs_readdata <= {29'h0, phase_r};
            bcc_pkg::ADDR_STATUS:   avs_readdata <= {31'h0, flag_r};
            bcc_pkg::ADDR_MASK:     avs_readdata <= {31'h0, mask_r};
            bcc_pkg::ADDR_STATE:    avs_readdata <= {19'h0, setpoint_r, 2'h0, otp_ind,
                                                     mode_r, sq.discharge,
                                                     regulator_enable_o};
            default:                avs_readdata <= 32'h0;
         endcase
      end
   end

   // ****************************************************************
   // Decoders
   // ****************************************************************
   function automatic logic [8:0] sp_volts(input logic [4:0] c);
      logic [4:0] k;
      k = (c > bcc_pkg::SP_MAX_CODE) ? bcc_pkg::SP_MAX_CODE : c;
      unique case (k)
         5'h00: sp_volts = 9'd100;  5'h01: sp_volts = 9'd110;
         5'h02: sp_volts = 9'd120;  5'h03: sp_volts = 9'd125;
         5'h04: sp_volts = 9'd130;  5'h05: sp_volts = 9'd135;
         5'h06: sp_volts = 9'd150;  5'h07: sp_volts = 9'd160;
         5'h08: sp_volts = 9'd180;  5'h09: sp_volts = 9'd185;
         5'h0A: sp_volts = 9'd200;  5'h0B: sp_volts = 9'd210;
         5'h0C: sp_volts = 9'd215;  5'h0D: sp_volts = 9'd225;
         5'h0E: sp_volts = 9'd230;  5'h0F: sp_volts = 9'd240;
         5'h10: sp_volts = 9'd250;  5'h11: sp_volts = 9'd280;
         5'h12: sp_volts = 9'd315;  5'h13: sp_volts = 9'd320;
         5'h14: sp_volts = 9'd325;  5'h15: sp_volts = 9'd330;
         5'h16: sp_volts = 9'd335;  5'h17: sp_volts = 9'd340;
         5'h18: sp_volts = 9'd350;  5'h19: sp_volts = 9'd380;
         5'h1A: sp_volts = 9'd400;  default: sp_volts = 9'd410;
      endcase
   endfunction

   // 111 wraps to 0, others are (code+1)*45
   function automatic logic [8:0] ph_deg(input logic [2:0] p);
      ph_deg = (p == bcc_pkg::PHASE_ZERO) ? 9'h0 : 9'(({6'h0, p} + 9'h1) * 9'd45);
   endfunction

   // ****************************************************************
   // Registered outputs
   // ****************************************************************
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         output_setpoint_code_o      <= 5'h0;
         operating_mode_field_o      <= bcc_pkg::MODE_OFF;
         regulator_enable_o          <= 1'b0;
         discharge_o                 <= 1'b0;
         peak_current_limit_select_o <= bcc_pkg::ILIM_RST;
         channel_phase_select_o      <= bcc_pkg::PHASE_ZERO;
         phase_degrees_o             <= 9'h0;
         setpoint_centivolt_o        <= 9'h0;
         inductor_value_select_o     <= 2'h0;
         inductor_reserved_o         <= 1'b0;
         interrupt_request_n_o       <= 1'b1;
      end else begin
         output_setpoint_code_o      <= setpoint_r;
         operating_mode_field_o      <= mode_r;
         // Off mode or a running sequence disables the regulator
         regulator_enable_o          <= (mode_r != bcc_pkg::MODE_OFF) && !sq.busy;
         discharge_o                 <= sq.discharge || (loaded_r &&
                                        mode_r == bcc_pkg::MODE_OFF);
         peak_current_limit_select_o <= ilim_r;
         channel_phase_select_o      <= phase_r;
         phase_degrees_o             <= ph_deg(phase_r);
         setpoint_centivolt_o        <= sp_volts(setpoint_r);
         inductor_value_select_o     <= otp_ind;
         inductor_reserved_o         <= (otp_ind == bcc_pkg::IND_RESERVED);
         interrupt_request_n_o       <= !(flag_r && !mask_r[0]);
      end
   end

   // ****************************************************************
   // Assertions
   // ****************************************************************
   a_flag_on_change: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      mode_evt |=> flag_r) else $error("Mode change did not set flag");
   a_irq_follows: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      (flag_r && !mask_r[0]) |=> !interrupt_request_n_o) else $error("Interrupt not driven");
   a_irq_masked: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      mask_r[0] |=> interrupt_request_n_o) else $error("Masked interrupt driven");
   a_flag_sticky: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      (flag_r && !(rd_acc && avs_address == bcc_pkg::ADDR_STATUS)) |=> flag_r)
      else $error("Flag dropped without clear");
   a_same_sp_quiet: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      (wr_acc && avs_address == bcc_pkg::ADDR_SETPOINT && avs_writedata[4:0] == setpoint_r)
      |-> !sq.start) else $error("Equal set-point restarted sequence");
   a_seq_disable: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      sp_start |=> ##1 (!regulator_enable_o && discharge_o))
      else $error("Set-point change did not discharge");
   a_otp_load: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      load_now |=> (setpoint_r == $past(otp_sp))) else $error("OTP set-point not loaded");
   a_mode_reset: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      load_now |=> (run_mode_r == (pwr_seq ? bcc_pkg::MODE_AUTOSKIP : bcc_pkg::MODE_OFF)))
      else $error("Run mode default wrong");
   a_volt_clamp: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      (setpoint_r >= bcc_pkg::SP_MAX_CODE) |=> (setpoint_centivolt_o == 9'd410))
      else $error("High codes not clamped");
   // Off mode must never leave the regulator switching
   a_off_disabled: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      (mode_r == bcc_pkg::MODE_OFF) |=> !regulator_enable_o)
      else $error("Regulator enabled in off mode");
   a_ind_reserved: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      (otp_ind == bcc_pkg::IND_RESERVED) |=> inductor_reserved_o)
      else $error("Reserved inductor code not flagged");

   c_sp_change: cover property (@(posedge sys_clk_i) sp_start);
   c_mode_irq:  cover property (@(posedge sys_clk_i) $fell(interrupt_request_n_o));
   c_standby:   cover property (@(posedge sys_clk_i) $rose(stby) ##[1:4] mode_evt);
   c_reenable:  cover property (@(posedge sys_clk_i) sq.done);

endmodule
`default_nettype wire

// File: bcc_host_model.sv
// Host model: Avalon-MM master standing where the host processor sits.
// Assumes one clock shared with the block; the bench calls its tasks.
`timescale 1ns/1ps
`default_nettype none
module bcc_host_model (
   input  wire logic        sys_clk_i,
   input  wire logic        avs_waitrequest,
   output logic [2:0]       avs_address,
   output logic             avs_read,
   output logic             avs_write,
   output logic [31:0]      avs_writedata
);
   logic wq_s;  // Waitrequest as it stands before the next rising edge
   initial begin
      avs_address = 3'h0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
   end
   // Copy taken mid-cycle, so the edge sees the settled value, not a race
   always @(negedge sys_clk_i) wq_s = avs_waitrequest;
   // One access, held until waitrequest is seen low at a rising edge
   task automatic xfer(input logic [2:0] a, input logic rd, input logic [31:0] d);
      @(posedge sys_clk_i);
      avs_address <= a;
      avs_read <= rd;
      avs_write <= ~rd;
      avs_writedata <= d;
      do @(posedge sys_clk_i); while (wq_s !== 1'b0);
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
endmodule
`default_nettype wire

// File: bcc_pkg.sv
// Package for the buck channel configuration control block.
// Assumes a single 200 MHz clock domain; used by the control block, the sequencer and the bench through bcc_pkg::name.
`default_nettype none
package bcc_pkg;

   // ****************************************************************
   // Register map (word addresses on the Avalon-MM slave)
   // ****************************************************************
   localparam logic [2:0] ADDR_SETPOINT = 3'h0;  // Set-point code
   localparam logic [2:0] ADDR_MODE     = 3'h1;  // Run [1:0], standby [3:2]
   localparam logic [2:0] ADDR_LIMIT    = 3'h2;  // Peak current limit
   localparam logic [2:0] ADDR_PHASE    = 3'h3;  // Phase select
   localparam logic [2:0] ADDR_STATUS   = 3'h4;  // Sticky flags, read clears
   localparam logic [2:0] ADDR_MASK     = 3'h5;  // Interrupt mask
   localparam logic [2:0] ADDR_STATE    = 3'h6;  // Live channel state

   // ****************************************************************
   // Field positions
   // ****************************************************************
   localparam int RUN_MODE_LSB   = 0;
   localparam int STBY_MODE_LSB  = 2;
   localparam int ST_EN_BIT      = 0;   // Regulator enabled
   localparam int ST_DIS_BIT     = 1;   // Discharging
   localparam int ST_MODE_LSB    = 2;   // Applied mode [3:2]
   localparam int ST_IND_LSB     = 4;   // Inductor select [5:4]
   localparam int ST_SP_LSB      = 8;   // Applied set-point [12:8]

   // ****************************************************************
   // Reset values and encodings
   // ****************************************************************
   localparam logic [1:0] MODE_OFF      = 2'h0;
   localparam logic [1:0] MODE_PWM      = 2'h1;
   localparam logic [1:0] MODE_PFM      = 2'h2;
   localparam logic [1:0] MODE_AUTOSKIP = 2'h3;
   localparam logic [1:0] ILIM_RST      = 2'h0;
   localparam logic [2:0] PHASE_ZERO    = 3'h7;  // Code for 0 degrees
   localparam logic [0:0] MASK_RST      = 1'h1;
   localparam logic [4:0] SP_MAX_CODE   = 5'h1B; // Code 27, 4.10 V
   localparam logic [1:0] IND_RESERVED  = 2'h3;

   // ****************************************************************
   // Timing
   // ****************************************************************
   localparam int CLK_MHZ        = 200;
   localparam int DISCHARGE_US   = 200;  // Output discharge hold
   localparam int DISCHARGE_CYC  = DISCHARGE_US * CLK_MHZ;

   // Channel sequencing state
   typedef enum logic [1:0] {
      BCC_ST_IDLE,
      BCC_ST_DISCHARGE,
      BCC_ST_REENABLE
   } bcc_seq_type;

endpackage
`default_nettype wire

// File: bcc_seq_if.sv
// Interface joining the register file to the set-point sequencer.
// Assumes both ends sit on sys_clk_i.
`timescale 1ns/1ps
`default_nettype none
interface bcc_seq_if;
   logic       start;      // One-cycle request to re-apply the set-point
   logic [4:0] target;     // Newly written set-point code
   logic       discharge;  // Sequencer holds output discharged
   logic       busy;       // Sequence running
   logic       done;       // One-cycle pulse at end of sequence
   modport ctrl (output start, output target, input discharge, input busy, input done);
   modport seq  (input start, input target, output discharge, output busy, output done);
endinterface
`default_nettype wire

// File: bcc_setpoint_seq.sv
// Discharge-then-re-enable sequencer for set-point changes.
// Assumes start is a same-clock one-cycle pulse.
`timescale 1ns/1ps
`default_nettype none
module bcc_setpoint_seq #(
   parameter int DISCHARGE_CYC = bcc_pkg::DISCHARGE_CYC
) (
   input  wire logic  sys_clk_i,
   input  wire logic  sys_rst_i,
   bcc_seq_if.seq     sq
);

   // ****************************************************************
   // State and counter
   // ****************************************************************
   bcc_pkg::bcc_seq_type state_r;   // Sequencer state
   logic [31:0]          cnt_r;     // Discharge hold counter

   // Discharge first, then a single re-enable cycle
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         state_r <= bcc_pkg::BCC_ST_IDLE;
         cnt_r   <= 32'h0;
      end else begin
         unique case (state_r)
            bcc_pkg::BCC_ST_IDLE: begin
               if (sq.start) begin
                  state_r <= bcc_pkg::BCC_ST_DISCHARGE;
                  cnt_r   <= 32'h0;
               end
            end
            bcc_pkg::BCC_ST_DISCHARGE: begin
               // A new write restarts the hold so the output is fully drained
               if (sq.start) begin
                  cnt_r <= 32'h0;
               end else if (cnt_r == 32'(DISCHARGE_CYC - 1)) begin
                  state_r <= bcc_pkg::BCC_ST_REENABLE;
               end else begin
                  cnt_r <= cnt_r + 32'h1;
               end
            end
            bcc_pkg::BCC_ST_REENABLE: begin
               state_r <= bcc_pkg::BCC_ST_IDLE;
            end
         endcase
      end
   end

   assign sq.discharge = (state_r == bcc_pkg::BCC_ST_DISCHARGE);
   assign sq.busy      = (state_r != bcc_pkg::BCC_ST_IDLE);
   assign sq.done      = (state_r == bcc_pkg::BCC_ST_REENABLE);

   a_discharge_len: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      $rose(sq.discharge) |-> sq.discharge [*8])
      else $error("Discharge ended too early");

endmodule
`default_nettype wire

// File: buck_channel_config_control_tb.sv
// Self-checking bench for the buck channel control block.
// Assumes bcc_pkg and the design files are compiled first.
`timescale 1ns/1ps
`default_nettype none
module buck_channel_config_control_tb;
   localparam int DCYC = 16;  // Short discharge hold to keep the run brief
   logic clk = 1'b0, rst = 1'b1, stby = 1'b0;
   logic [4:0] otp = 5'h08;  // OTP set-point strap
   logic [1:0] ind_sel = 2'h1;  // OTP inductor strap
   logic pseq = 1'b1;  // Power-up sequence strap
   logic [2:0] a;
   logic rd, wr, wq;
   logic [31:0] wd, rdd;
   logic [4:0] sp;
   logic [1:0] md, ilim, ind;
   logic en, dis, irq_n, ind_res;
   logic [2:0] ph;
   logic [8:0] deg, cv;
   int fail_count = 0, checks_done = 0, cyc = 0;
   logic [31:0] exp_q[$];  // Expected read data, oldest first
   int codes[5] = '{0, 17, 26, 27, 31};
   int volts[5] = '{100, 280, 400, 410, 410};
   always #2.5 clk = ~clk;
   bcc_channel_ctrl #(.DISCHARGE_CYC(DCYC)) uut (.sys_clk_i(clk), .sys_rst_i(rst),
      .avs_address(a), .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
      .avs_readdata(rdd), .avs_waitrequest(wq), .otp_setpoint_default_i(otp),
      .inductor_value_select_i(ind_sel), .in_powerup_seq_i(pseq), .standby_i(stby),
      .output_setpoint_code_o(sp), .operating_mode_field_o(md), .regulator_enable_o(en),
      .discharge_o(dis), .peak_current_limit_select_o(ilim), .channel_phase_select_o(ph),
      .phase_degrees_o(deg), .setpoint_centivolt_o(cv), .inductor_value_select_o(ind),
      .inductor_reserved_o(ind_res), .interrupt_request_n_o(irq_n));
   bcc_host_model host (.sys_clk_i(clk), .avs_waitrequest(wq), .avs_address(a),
      .avs_read(rd), .avs_write(wr), .avs_writedata(wd));
   // Comparison of any value against its expectation
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rd_exp(input logic [2:0] ad, input logic [31:0] e);
      exp_q.push_back(e);
      host.xfer(ad, 1'b1, 32'h0);
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // Monitor: read data taken at the accept edge, against the oldest note
   always @(posedge clk) begin
      if (rd && host.wq_s === 1'b0) chk(rdd, exp_q.size() ? exp_q.pop_front() : 32'hX);
   end
   // Hang guard
   always @(posedge clk) begin
      cyc++;
      if (cyc > 20000) begin
         fail_count++;
         end_sim();
      end
   end
   task automatic end_sim();
      // A note never taken off the queue is a read that was never checked
      if (exp_q.size() != 0) fail_count++;
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      void'($urandom(11938));
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      // ******************** Power-up defaults ********************
      rd_exp(bcc_pkg::ADDR_SETPOINT, 32'h8);
      rd_exp(bcc_pkg::ADDR_MODE, 32'hF);
      rd_exp(bcc_pkg::ADDR_PHASE, 32'h7);
      rd_exp(bcc_pkg::ADDR_MASK, 32'h1);
      rd_exp(3'h7, 32'h0);
      settle(1);
      chk(32'(cv), 32'd180);
      chk(32'(deg), 32'd0);
      chk({30'h0, ind}, 32'h1);
      chk(32'(ind_res), 32'h0);
      // ******************** Set-point changes ********************
      for (int i = 0; i < 5; i++) begin
         host.xfer(bcc_pkg::ADDR_SETPOINT, 1'b0, 32'(codes[i]));
         settle(2);
         chk({31'h0, dis}, 32'h1);
         chk({31'h0, en}, 32'h0);
         settle(DCYC + 4);
         chk({31'h0, en}, 32'h1);
         chk(32'(sp), 32'(codes[i]));
         chk(32'(cv), 32'(volts[i]));
      end
      host.xfer(bcc_pkg::ADDR_SETPOINT, 1'b0, 32'd31);
      settle(3);
      chk({31'h0, dis}, 32'h0);
      // ******************** Limit and phase tables ********************
      for (int i = 0; i < 4; i++) begin
         host.xfer(bcc_pkg::ADDR_LIMIT, 1'b0, ($urandom & 32'hFFFFFFFC) | 32'(i));
         settle(2);
         chk(32'(ilim), 32'(i));
      end
      for (int i = 0; i < 8; i++) begin
         host.xfer(bcc_pkg::ADDR_PHASE, 1'b0, 32'(i));
         settle(3);
         chk(32'(deg), (i == 7) ? 32'd0 : 32'((i + 1) * 45));
         chk(32'(ph), 32'(i));
      end
      // ******************** Modes and interrupt ********************
      rd_exp(bcc_pkg::ADDR_STATUS, 32'h1);
      host.xfer(bcc_pkg::ADDR_MASK, 1'b0, 32'h0);
      for (int i = 0; i < 4; i++) begin
         host.xfer(bcc_pkg::ADDR_MODE, 1'b0, 32'((i << 2) | i));
         settle(3);
         chk(32'(md), 32'(i));
         chk({31'h0, irq_n}, 32'h0);
         rd_exp(bcc_pkg::ADDR_STATUS, 32'h1);
         settle(3);
         chk({31'h0, irq_n}, 32'h1);
      end
      host.xfer(bcc_pkg::ADDR_MASK, 1'b0, 32'h1);
      host.xfer(bcc_pkg::ADDR_MODE, 1'b0, 32'h5);
      settle(3);
      chk({31'h0, irq_n}, 32'h1);
      // ******************** Run to standby, same enable ********************
      @(posedge clk) stby <= 1'b1;
      settle(8);
      chk(32'(sp), 32'd31);
      chk({31'h0, en}, 32'h1);
      rd_exp(bcc_pkg::ADDR_STATE, 32'h1F15);
      // ******************** Second reset, other straps ********************
      @(posedge clk) begin
         rst <= 1'b1;
         otp <= 5'h1C;
         ind_sel <= 2'h3;
         pseq <= 1'b0;
         stby <= 1'b0;
      end
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      rd_exp(bcc_pkg::ADDR_SETPOINT, 32'h1C);
      rd_exp(bcc_pkg::ADDR_MODE, 32'h0);
      settle(2);
      chk(32'(cv), 32'd410);
      chk({30'h0, ind}, 32'h3);
      chk(32'(ind_res), 32'h1);
      chk({31'h0, en}, 32'h0);
      end_sim();
   end
endmodule
`default_nettype wire
